// [rtl/gpc_pkg.sv]
// Constants, drive-mode encoding and pin map for the GPIO port controller
package gpc_pkg;

  localparam int GPC_NUM_PORTS = 5;
  localparam int GPC_PORT_W = 8;
  localparam int GPC_NPIN = GPC_NUM_PORTS * GPC_PORT_W;
  localparam int GPC_DM_W = 3;
  localparam int GPC_EDGE_W = 2;

  // Bonded pins: 4 on port 0, 6 on port 1, 2 on port 2, 1 on port 3, 2 on port 4
  localparam logic [GPC_NPIN-1:0] GPC_IMPL_MASK = 40'h03_0103_3f0f;
  // Pins that carry a fixed-function peripheral signal
  localparam logic [GPC_NPIN-1:0] GPC_PERIPH_MASK = 40'h03_0103_0f0f;

  typedef enum logic [GPC_DM_W-1:0] {
    GPC_DM_OFF = 3'h0,
    GPC_DM_INPUT = 3'h1,
    GPC_DM_WU_SD = 3'h2,
    GPC_DM_SU_WD = 3'h3,
    GPC_DM_OD_LO = 3'h4,
    GPC_DM_OD_HI = 3'h5,
    GPC_DM_STRONG = 3'h6,
    GPC_DM_WU_WD = 3'h7
  } gpc_dm_t;

  localparam logic [GPC_DM_W-1:0] GPC_DM_RESET = 3'h0;

  // Interrupt edge select
  localparam logic [GPC_EDGE_W-1:0] GPC_EDGE_NONE = 2'h0;
  localparam logic [GPC_EDGE_W-1:0] GPC_EDGE_RISE = 2'h1;
  localparam logic [GPC_EDGE_W-1:0] GPC_EDGE_FALL = 2'h2;
  localparam logic [GPC_EDGE_W-1:0] GPC_EDGE_BOTH = 2'h3;

endpackage : gpc_pkg

// [rtl/gpc_gpio_port.sv]
// GPIO port controller: five 8-bit ports with drive modes, hold, pin mux and port interrupts
//
// Function
// - Fifteen bonded pins are usable as plain I/O whenever their peripheral is not selected.
// - Pins are grouped in 8-bit ports and all control, output and pin-state bits are per pin.
// - Each pin offers eight drive modes from off through weak-up/weak-down.
// - Each pin selects a CMOS or LVTTL input threshold.
// - The output buffer enable acts separately from the drive mode; the input buffer enable is also gated off by drive mode off.
// - While hold is high every pin keeps its latched output and configuration.
// - Each pin selects a fast or reduced output slew rate.
// - During reset every pin buffer is forced off.
// - A per-pin mux picks GPIO data or the pin's fixed peripheral signal.
// - Output data is held per pin and pin state returns the sampled pin level.
// - A pin raises its interrupt condition only when its interrupt is enabled.
// - There is one interrupt request per port, five in all.
`timescale 1ns/1ps
`default_nettype none

module gpc_gpio_port
  import gpc_pkg::*;
#(
  parameter int NUM_PORTS = GPC_NUM_PORTS,
  parameter int PORT_W = GPC_PORT_W,
  parameter logic [GPC_NPIN-1:0] IMPL_MASK = GPC_IMPL_MASK,
  parameter logic [GPC_NPIN-1:0] PERIPH_MASK = GPC_PERIPH_MASK
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold,
  input wire logic [GPC_NPIN-1:0] out_data,
  input wire logic [GPC_NPIN*GPC_DM_W-1:0] drive_mode,
  input wire logic [GPC_NPIN-1:0] thresh_lvttl,
  input wire logic [GPC_NPIN-1:0] in_buf_en,
  input wire logic [GPC_NPIN-1:0] out_buf_en,
  input wire logic [GPC_NPIN-1:0] slew_slow,
  input wire logic [GPC_NPIN-1:0] periph_sel,
  input wire logic [GPC_NPIN-1:0] periph_out,
  input wire logic [GPC_NPIN-1:0] int_en,
  input wire logic [GPC_NPIN*GPC_EDGE_W-1:0] int_edge,
  input wire logic [GPC_NPIN-1:0] int_clr,
  input wire logic [GPC_NPIN-1:0] pad_in,
  output logic [GPC_NPIN-1:0] pad_out,
  output logic [GPC_NPIN-1:0] pad_oe,
  output logic [GPC_NPIN-1:0] pad_pull_up,
  output logic [GPC_NPIN-1:0] pad_pull_down,
  output logic [GPC_NPIN-1:0] pad_in_en,
  output logic [GPC_NPIN-1:0] pad_lvttl,
  output logic [GPC_NPIN-1:0] pad_slow,
  output logic [GPC_NPIN-1:0] pin_state,
  output logic [GPC_NPIN-1:0] int_status,
  output logic [NUM_PORTS-1:0] port_irq
);

  localparam int NPIN = NUM_PORTS * PORT_W;

  logic [GPC_DM_W-1:0] dm_reg [NPIN];
  logic [NPIN-1:0] data_reg;
  logic [NPIN-1:0] ie_reg;
  logic [NPIN-1:0] oe_en_reg;
  logic [NPIN-1:0] thr_reg;
  logic [NPIN-1:0] slew_reg;
  logic [NPIN-1:0] pin_state_reg;
  logic [NPIN-1:0] pin_prev_reg;
  logic [NPIN-1:0] status_reg;
  logic [NPIN-1:0] status_next;
  logic [NPIN-1:0] enabled_status;
  logic [NUM_PORTS-1:0] irq_reg;
  logic [NUM_PORTS-1:0] port_any;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic src_data;
      logic drv_oe;
      logic drv_val;
      logic pu;
      logic pd;
      logic dm_on;
      logic edge_hit;
      logic rise;
      logic fall;
      logic [GPC_EDGE_W-1:0] edge_sel;

      // Peripheral path exists only on its fixed pin
      assign src_data = (periph_sel[gi] && PERIPH_MASK[gi]) ? periph_out[gi] : out_data[gi];

      // Drive-mode latch, frozen while hold is high
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          dm_reg[gi] <= GPC_DM_RESET;
        end else if (!hold && IMPL_MASK[gi]) begin
          dm_reg[gi] <= drive_mode[gi*GPC_DM_W +: GPC_DM_W];
        end
      end

      // Output data latch; hold keeps the last level through deep sleep
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          data_reg[gi] <= 1'b0;
        end else if (!hold && IMPL_MASK[gi]) begin
          data_reg[gi] <= src_data;
        end
      end

      // Buffer enable latch
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          ie_reg[gi] <= 1'b0;
          oe_en_reg[gi] <= 1'b0;
        end else if (!hold && IMPL_MASK[gi]) begin
          ie_reg[gi] <= in_buf_en[gi];
          oe_en_reg[gi] <= out_buf_en[gi];
        end
      end

      // Threshold and slew latch
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          thr_reg[gi] <= 1'b0;
          slew_reg[gi] <= 1'b0;
        end else if (!hold && IMPL_MASK[gi]) begin
          thr_reg[gi] <= thresh_lvttl[gi];
          slew_reg[gi] <= slew_slow[gi];
        end
      end

      // Drive-mode decode into strong drive and weak pulls
      // Every mode spells out all five terms so no branch can leave a stale drive
      always_comb begin
        case (gpc_dm_t'(dm_reg[gi]))
          GPC_DM_OFF: begin
            drv_oe = 1'b0;
            drv_val = 1'b0;
            pu = 1'b0;
            pd = 1'b0;
            dm_on = 1'b0;
          end
          GPC_DM_INPUT: begin
            drv_oe = 1'b0;
            drv_val = 1'b0;
            pu = 1'b0;
            pd = 1'b0;
            dm_on = 1'b1;
          end
          GPC_DM_WU_SD: begin
            drv_oe = !data_reg[gi];
            drv_val = 1'b0;
            pu = data_reg[gi];
            pd = 1'b0;
            dm_on = 1'b1;
          end
          GPC_DM_SU_WD: begin
            drv_oe = data_reg[gi];
            drv_val = 1'b1;
            pu = 1'b0;
            pd = !data_reg[gi];
            dm_on = 1'b1;
          end
          GPC_DM_OD_LO: begin
            drv_oe = !data_reg[gi];
            drv_val = 1'b0;
            pu = 1'b0;
            pd = 1'b0;
            dm_on = 1'b1;
          end
          GPC_DM_OD_HI: begin
            drv_oe = data_reg[gi];
            drv_val = 1'b1;
            pu = 1'b0;
            pd = 1'b0;
            dm_on = 1'b1;
          end
          GPC_DM_STRONG: begin
            drv_oe = 1'b1;
            drv_val = data_reg[gi];
            pu = 1'b0;
            pd = 1'b0;
            dm_on = 1'b1;
          end
          GPC_DM_WU_WD: begin
            drv_oe = 1'b0;
            drv_val = 1'b0;
            pu = data_reg[gi];
            pd = !data_reg[gi];
            dm_on = 1'b1;
          end
          default: begin
            drv_oe = 1'b0;
            drv_val = 1'b0;
            pu = 1'b0;
            pd = 1'b0;
            dm_on = 1'b0;
          end
        endcase
      end

      // Pad drive; output buffer enable gates drive and pulls alike
      // Pulls follow the buffer so a disabled pin loads nothing on the board
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pad_out[gi] <= 1'b0;
          pad_oe[gi] <= 1'b0;
          pad_pull_up[gi] <= 1'b0;
          pad_pull_down[gi] <= 1'b0;
        end else begin
          pad_out[gi] <= drv_val && drv_oe && oe_en_reg[gi];
          pad_oe[gi] <= drv_oe && oe_en_reg[gi];
          pad_pull_up[gi] <= pu && oe_en_reg[gi];
          pad_pull_down[gi] <= pd && oe_en_reg[gi];
        end
      end

      // Input buffer and pad options
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pad_in_en[gi] <= 1'b0;
          pad_lvttl[gi] <= 1'b0;
          pad_slow[gi] <= 1'b0;
        end else begin
          pad_in_en[gi] <= ie_reg[gi] && dm_on;
          pad_lvttl[gi] <= thr_reg[gi];
          pad_slow[gi] <= slew_reg[gi];
        end
      end

      // Pin sampling; a disabled input buffer reads as zero
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pin_state_reg[gi] <= 1'b0;
        end else begin
          pin_state_reg[gi] <= pad_in[gi] && pad_in_en[gi] && IMPL_MASK[gi];
        end
      end

      // Previous sample for edge detection; resets to the idle low of a masked pin
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pin_prev_reg[gi] <= 1'b0;
        end else begin
          pin_prev_reg[gi] <= pin_state_reg[gi];
        end
      end

      assign edge_sel = int_edge[gi*GPC_EDGE_W +: GPC_EDGE_W];
      assign rise = pin_state_reg[gi] && !pin_prev_reg[gi];
      assign fall = !pin_state_reg[gi] && pin_prev_reg[gi];
      always_comb begin
        case (edge_sel)
          GPC_EDGE_NONE: begin
            edge_hit = 1'b0;
          end
          GPC_EDGE_RISE: begin
            edge_hit = rise;
          end
          GPC_EDGE_FALL: begin
            edge_hit = fall;
          end
          GPC_EDGE_BOTH: begin
            edge_hit = rise || fall;
          end
          default: begin
            edge_hit = 1'b0;
          end
        endcase
      end

      // Set beats clear so an edge landing on the clear is kept
      assign status_next[gi] = (edge_hit && int_en[gi]) || (status_reg[gi] && !int_clr[gi]);
      assign enabled_status[gi] = status_reg[gi] && int_en[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next & IMPL_MASK;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      // Masking by enable lets software park a pending pin without losing it
      assign port_any[gp] = |enabled_status[gp*PORT_W +: PORT_W];

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          irq_reg[gp] <= 1'b0;
        end else begin
          irq_reg[gp] <= port_any[gp];
        end
      end
    end
  endgenerate

  assign pin_state = pin_state_reg;
  assign int_status = status_reg;
  assign port_irq = irq_reg;

endmodule : gpc_gpio_port

`default_nettype wire

// [bench/gpc_gpio_port_props.sv]
// Port-level assertions for the GPIO port controller
`timescale 1ns/1ps
`default_nettype none
module gpc_gpio_port_props
  import gpc_pkg::*;
#(
  parameter int NUM_PORTS = GPC_NUM_PORTS,
  parameter logic [GPC_NPIN-1:0] IMPL_MASK = GPC_IMPL_MASK
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold,
  input wire logic [GPC_NPIN-1:0] out_data,
  input wire logic [GPC_NPIN*GPC_DM_W-1:0] drive_mode,
  input wire logic [GPC_NPIN-1:0] out_buf_en,
  input wire logic [GPC_NPIN-1:0] periph_sel,
  input wire logic [GPC_NPIN-1:0] int_en,
  input wire logic [GPC_NPIN-1:0] int_clr,
  input wire logic [GPC_NPIN-1:0] pad_in,
  input wire logic [GPC_NPIN-1:0] pad_out,
  input wire logic [GPC_NPIN-1:0] pad_oe,
  input wire logic [GPC_NPIN-1:0] pad_in_en,
  input wire logic [GPC_NPIN-1:0] pin_state,
  input wire logic [GPC_NPIN-1:0] int_status,
  input wire logic [NUM_PORTS-1:0] port_irq
);
  logic [NUM_PORTS-1:0] irq_exp;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      irq_exp[p] = |(int_status[p*GPC_PORT_W +: GPC_PORT_W] & int_en[p*GPC_PORT_W +: GPC_PORT_W]);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_RESET_OFF: assert property (disable iff (1'b0)
    !reset_n |=> (pad_oe | pad_in_en | int_status) == '0) else $error("pins live in reset");
  AST_UNBONDED: assert property (((pad_oe | pad_in_en) & ~IMPL_MASK) == '0)
    else $error("unbonded pin active");
  AST_HOLD: assert property (hold [*2] |=> $stable(pad_oe) && $stable(pad_out))
    else $error("pin moved in hold");
  AST_PIN_STATE: assert property (1'b1 |=> pin_state == ($past(pad_in) & $past(pad_in_en)))
    else $error("pin state wrong");
  AST_INT_EN: assert property ($past(reset_n) |->
    (int_status & ~$past(int_status) & ~$past(int_en)) == '0) else $error("status while masked");
  AST_STICKY: assert property ($past(reset_n) |->
    (~int_status & $past(int_status) & ~$past(int_clr)) == '0) else $error("status lost");
  AST_IRQ: assert property (1'b1 |=> port_irq == $past(irq_exp))
    else $error("port request wrong");
  AST_STRONG: assert property ((drive_mode[2:0] == GPC_DM_STRONG && out_buf_en[0]
    && !periph_sel[0] && !hold) [*2] |=> pad_oe[0] && pad_out[0] == $past(out_data[0], 2))
    else $error("strong drive wrong");
  cover property (|port_irq);
  cover property (hold [*2]);
  cover property (pad_oe[0]);
endmodule : gpc_gpio_port_props
bind gpc_gpio_port gpc_gpio_port_props #(.NUM_PORTS(NUM_PORTS), .IMPL_MASK(IMPL_MASK))
  gpc_gpio_port_props_i (.*);
`default_nettype wire

// [bench/gpc_board.sv]
// Board-side pin model: drivers, pulls and an external source
`timescale 1ns/1ps
`default_nettype none
module gpc_board
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic [GPC_NPIN-1:0] pad_out,
  input wire logic [GPC_NPIN-1:0] pad_oe,
  input wire logic [GPC_NPIN-1:0] pad_pull_up,
  input wire logic [GPC_NPIN-1:0] pad_pull_down,
  input wire logic [GPC_NPIN-1:0] ext_en,
  input wire logic [GPC_NPIN-1:0] ext_val,
  output logic [GPC_NPIN-1:0] pad_in
);
  logic float_reg = 1'b0;
  // Floating pins wander so a stale level is never trusted
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pad_pull_up | (~pad_pull_down & {GPC_NPIN{float_reg}})));
  end
endmodule : gpc_board
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking testbench for the GPIO port controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpc_pkg::*;
  localparam logic [GPC_NPIN-1:0] LIVE = GPC_IMPL_MASK;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hold = 1'b0;
  logic [GPC_NPIN-1:0] out_data = '0, thresh_lvttl = '0, in_buf_en = '0, out_buf_en = '0;
  logic [GPC_NPIN-1:0] slew_slow = '0, periph_sel = '0, periph_out = '0, int_en = '0;
  logic [GPC_NPIN-1:0] int_clr = '0, ext_en = '0, ext_val = '0;
  logic [GPC_NPIN*GPC_DM_W-1:0] drive_mode = '0;
  logic [GPC_NPIN*GPC_EDGE_W-1:0] int_edge = '0;
  logic [GPC_NPIN-1:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_in_en;
  logic [GPC_NPIN-1:0] pad_lvttl, pad_slow, pin_state, int_status;
  logic [GPC_NUM_PORTS-1:0] port_irq;
  int n_errors = 0;
  int compares = 0;
  // Row: mode, data, out enable, then expected oe, out, pull-up, pull-down
  logic [8:0] rows [13] = '{9'h1bc, 9'h198, 9'h1a0, 9'h030, 9'h070, 9'h0b2, 9'h098,
    9'h0d1, 9'h0fc, 9'h118, 9'h17c, 9'h1d1, 9'h1f2};
  gpc_gpio_port gpc_gpio_port_i (.*);
  gpc_board gpc_board_i (.*);
  always #25 clk = ~clk;
  task automatic check(input string what, input logic [GPC_NPIN-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic end_sim();
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    step(6);
    reset_n = 1'b1;
    thresh_lvttl = 40'h55_5555_5555;
    slew_slow = 40'haa_aaaa_aaaa;
    in_buf_en = '1;
    foreach (rows[i]) begin
      drive_mode = {GPC_NPIN{rows[i][8:6]}};
      out_data = {GPC_NPIN{rows[i][5]}};
      out_buf_en = {GPC_NPIN{rows[i][4]}};
      step(3);
      check("pad_oe", pad_oe, {GPC_NPIN{rows[i][3]}} & LIVE);
      check("pad_out", pad_out, {GPC_NPIN{rows[i][2]}} & LIVE);
      check("pad_pull_up", pad_pull_up, {GPC_NPIN{rows[i][1]}} & LIVE);
      check("pad_pull_down", pad_pull_down, {GPC_NPIN{rows[i][0]}} & LIVE);
      check("pad_in_en", pad_in_en, (rows[i][8:6] != 3'h0) ? LIVE : '0);
    end
    check("pad_lvttl", pad_lvttl, thresh_lvttl & LIVE);
    check("pad_slow", pad_slow, slew_slow & LIVE);
    for (int m = 2; m < 8; m++) begin
      drive_mode = {GPC_NPIN{m[2:0]}};
      step(3);
      check("pad_in_en", pad_in_en, LIVE);
    end
    drive_mode = {GPC_NPIN{GPC_DM_STRONG}};
    out_data = '0;
    out_buf_en = '1;
    periph_out = '1;
    periph_sel = '1;
    step(3);
    check("pad_out", pad_out, GPC_PERIPH_MASK & LIVE);
    periph_sel = '0;
    out_data = '1;
    step(3);
    hold = 1'b1;
    out_data = '0;
    drive_mode = '0;
    step(3);
    check("pad_oe", pad_oe, LIVE);
    check("pad_out", pad_out, LIVE);
    hold = 1'b0;
    step(3);
    check("pad_oe", pad_oe, '0);
    drive_mode = {GPC_NPIN{GPC_DM_INPUT}};
    out_buf_en = '0;
    ext_en = '1;
    int_edge = {GPC_NPIN{GPC_EDGE_RISE}};
    int_en = LIVE;
    step(3);
    ext_val = 40'h00_0000_0100;
    step(3);
    check("pin_state", pin_state, ext_val);
    check("int_status", int_status, ext_val);
    check("port_irq", port_irq, 5'h02);
    ext_val = '0;
    step(3);
    check("int_status", int_status, 40'h00_0000_0100);
    int_en = '0;
    step(3);
    check("port_irq", port_irq, 5'h00);
    int_clr = 40'h00_0000_0100;
    step(1);
    int_clr = '0;
    ext_val = 40'h00_0000_0200;
    step(3);
    check("int_status", int_status, '0);
    ext_val = '0;
    int_en = LIVE;
    step(3);
    ext_val = LIVE;
    step(3);
    check("port_irq", port_irq, 5'h1f);
    int_clr = '1;
    step(1);
    int_clr = '0;
    int_edge = {GPC_NPIN{GPC_EDGE_FALL}};
    ext_val = 40'h00_0000_0001;
    step(3);
    check("int_status", int_status, LIVE & 40'hff_ffff_fffe);
    int_edge = {GPC_NPIN{GPC_EDGE_BOTH}};
    int_clr = '1;
    ext_val = LIVE;
    step(2);
    check("int_status", int_status, LIVE & 40'hff_ffff_fffe);
    int_clr = '0;
    reset_n = 1'b0;
    step(2);
    check("pad_in_en", pad_in_en, '0);
    check("port_irq", port_irq, 5'h00);
    reset_n = 1'b1;
    step(1);
    end_sim();
  end
  initial begin
    #1_000_000;
    n_errors++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
